// ==== hw/dtx_pkg.sv ====
// dtx_pkg: opcode patterns, instruction classes and minimum clock counts
// for the data-transfer decoder.
// assumes: the user holds the 16-bit-bus or the 8-bit-bus variant selection
package dtx_pkg;
   // opcode patterns (mask, match)
   localparam logic [7:0] OP_SEG_LOAD = 8'h8E; // rm to segment
   localparam logic [7:0] OP_SEG_STORE = 8'h8C; // segment to rm
   localparam logic [7:0] OP_TABLE = 8'hD7;
   localparam logic [7:0] OP_EA_LOAD = 8'h8D;
   localparam logic [7:0] OP_PTR_DS = 8'hC5;
   localparam logic [7:0] OP_PTR_ES = 8'hC4;
   localparam logic [7:0] OP_FL_TO_AH = 8'h9F;
   localparam logic [7:0] OP_AH_TO_FL = 8'h9E;
   localparam logic [7:0] OP_FL_SAVE = 8'h9C;
   localparam logic [7:0] OP_FL_REST = 8'h9D;
   localparam logic [7:0] OP_SAVE_ALL = 8'h60;
   localparam logic [7:0] OP_REST_ALL = 8'h61;
   localparam logic [7:0] OP_SAVE_MEM = 8'hFF;
   localparam logic [7:0] OP_REST_MEM = 8'h8F;
   localparam logic [7:0] M_W = 8'hFE; // ignore w bit
   localparam logic [7:0] M_REG = 8'hF8; // ignore reg field
   localparam logic [7:0] M_SEGR = 8'hE7; // ignore seg reg field
   localparam logic [7:0] M_IMM4 = 8'hF0; // 1011w-reg form
   localparam logic [7:0] M_SIMM = 8'hFD; // ignore s bit
   localparam logic [7:0] OP_R_TO_RM = 8'h88;
   localparam logic [7:0] OP_RM_TO_R = 8'h8A;
   localparam logic [7:0] OP_IMM_RM = 8'hC6;
   localparam logic [7:0] OP_IMM_R = 8'hB0;
   localparam logic [7:0] OP_MEM_ACC = 8'hA0;
   localparam logic [7:0] OP_ACC_MEM = 8'hA2;
   localparam logic [7:0] OP_SWAP_RM = 8'h86;
   localparam logic [7:0] OP_SWAP_ACC = 8'h90;
   localparam logic [7:0] OP_SAVE_REG = 8'h50;
   localparam logic [7:0] OP_REST_REG = 8'h58;
   localparam logic [7:0] OP_SAVE_SEG = 8'h06;
   localparam logic [7:0] OP_REST_SEG = 8'h07;
   localparam logic [7:0] OP_SAVE_IMM = 8'h68;
   localparam logic [7:0] OP_IN_FIX = 8'hE4;
   localparam logic [7:0] OP_OUT_FIX = 8'hE6;
   localparam logic [7:0] OP_IN_VAR = 8'hEC;
   localparam logic [7:0] OP_OUT_VAR = 8'hEE;
   localparam logic [1:0] MOD_REG = 2'h3; // register operand
   // minimum clock counts
   localparam logic [7:0] C_SEGLD_R = 8'h02;
   localparam logic [7:0] C_SEGLD_M16 = 8'h09;
   localparam logic [7:0] C_SEGLD_M8 = 8'h0D;
   localparam logic [7:0] C_SEGST_R = 8'h02;
   localparam logic [7:0] C_SEGST_M16 = 8'h0B;
   localparam logic [7:0] C_SEGST_M8 = 8'h0F;
   localparam logic [7:0] C_TBL16 = 8'h0B;
   localparam logic [7:0] C_TBL8 = 8'h0F;
   localparam logic [7:0] C_EA = 8'h06;
   localparam logic [7:0] C_PTR16 = 8'h12;
   localparam logic [7:0] C_PTR8 = 8'h1A;
   localparam logic [7:0] C_FL_AH = 8'h02;
   localparam logic [7:0] C_AH_FL = 8'h03;
   localparam logic [7:0] C_DEFAULT = 8'h02; // classes without a count
   localparam int Q16_DEPTH = 6;
   localparam int Q8_DEPTH = 4;
   localparam logic [1:0] HS_EXTRA_MAX = 2'h2; // handshake slack, clocks

   typedef enum logic [4:0] {
      DTX_NONE, DTX_SEG_LOAD, DTX_SEG_STORE, DTX_TABLE, DTX_EA_LOAD,
      DTX_PTR_DS, DTX_PTR_ES, DTX_FL_TO_AH, DTX_AH_TO_FL, DTX_FL_SAVE,
      DTX_FL_REST, DTX_XFER, DTX_SWAP, DTX_SAVE, DTX_REST, DTX_PORT_FIX,
      DTX_PORT_VAR, DTX_ILLEGAL
   } dtx_class_e;

   typedef struct packed {
      dtx_class_e cls;
      logic mem; // waits on the bus unit for its memory access
      logic needs_modrm;
      logic [7:0] clocks;
   } dtx_dec_s;
endpackage

// ==== hw/dtx_decoder.sv ====
// dtx_decoder: decodes one data-transfer instruction taken from the
// prefetch queue and times its execution.
// assumes: queue bytes arrive with a valid level; bus unit acks memory.
// Functional notes
// [RULE1] each count is the minimum, operands assumed already queued
// [RULE2] jump and call counts include the fetch at the destination
// [RULE3] memory instructions may stretch one or two clocks by handshake
// [RULE4] 16-bit-bus variant holds six queued instruction bytes
// [RULE5] 8-bit-bus variant uses a four-byte queue, often under-filled
// [RULE6] 10001110 moves rm to segment: 2 reg, 9 mem, 13 on 8-bit
// [RULE7] 10001100 copies segment to rm: 2 reg, 11 mem, 15 on 8-bit
// [RULE8] 11010111 table lookup into low accumulator: 11, or 15 on 8-bit
// [RULE9] 10001101 loads effective address, no memory access, 6 clocks
// [RULE10] 11000101 pointer load with data segment, mod not 11, 18/26
// [RULE11] 11000100 pointer load with extra segment, mod not 11, 18/26
// [RULE12] 10011111 flags low byte to high accumulator, 2 clocks
// [RULE13] 10011110 high accumulator into flags low byte, 3 clocks
// [RULE14] general transfers and swaps decode with their listed patterns
// [RULE15] stack saves, restores and flag save/restore decode as listed
// [RULE16] port forms: fixed port byte, or port address from register
`timescale 1ns/1ns
module dtx_decoder
   import dtx_pkg::*;
#(
   parameter bit NARROW_BUS = 1'b0 // 1 selects the 8-bit-bus variant
)(
   input wire logic i_ref_clk, // 125 MHz core clock
   input wire logic i_rstn, // synchronous reset, active low
   input wire logic i_q_valid, // queue byte available
   input wire logic [7:0] i_q_byte, // queue head byte
   input wire logic i_mem_ack, // bus unit finished memory access
   output logic o_q_pop, // take the queue head this cycle
   output logic o_busy, // an instruction is executing
   output logic o_done, // one-cycle pulse: instruction retired
   output dtx_class_e o_class, // class of last decoded instruction
   output logic [7:0] o_clocks, // minimum clocks of that instruction
   output logic o_illegal, // mod 11 on pointer loads
   output logic [3:0] o_q_depth // queue depth of this variant
);
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_OPC, ST_MODRM, ST_EXEC, ST_WAIT} dtx_st_e;
   localparam logic [3:0] QDEPTH = NARROW_BUS ? 4'(Q8_DEPTH) : 4'(Q16_DEPTH);
   // the take edge and the retire edge both belong to the count, so the
   // counter starts lower by the clocks already spent on queue bytes
   localparam logic [7:0] OPC_SPENT = 8'h02;
   localparam logic [7:0] PAIR_SPENT = 8'h03;

   dtx_st_e st_r, st_nxt;
   logic [7:0] opc_r, opc_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [1:0] hs_r, hs_nxt;
   dtx_dec_s dec_r, dec_nxt;
   logic ill_r, ill_nxt;
   logic done_r, done_nxt;
   dtx_dec_s d;

   ////////////////////////////////////////////////////////////////////
   // classify the opcode byte alone
   function automatic dtx_dec_s classify(input logic [7:0] op);
      dtx_dec_s r;
      r = '{cls: DTX_NONE, mem: 1'b0, needs_modrm: 1'b0, clocks: C_DEFAULT};
      unique casez (1'b1)
         op == OP_SEG_LOAD: r = '{DTX_SEG_LOAD, 1'b0, 1'b1, C_SEGLD_R}; // RULE6
         op == OP_SEG_STORE: r = '{DTX_SEG_STORE, 1'b0, 1'b1, C_SEGST_R}; // RULE7
         op == OP_TABLE: // RULE8
            r = '{DTX_TABLE, 1'b1, 1'b0, NARROW_BUS ? C_TBL8 : C_TBL16};
         op == OP_EA_LOAD: r = '{DTX_EA_LOAD, 1'b0, 1'b1, C_EA}; // RULE9
         op == OP_PTR_DS: // RULE10
            r = '{DTX_PTR_DS, 1'b1, 1'b1, NARROW_BUS ? C_PTR8 : C_PTR16};
         op == OP_PTR_ES: // RULE11
            r = '{DTX_PTR_ES, 1'b1, 1'b1, NARROW_BUS ? C_PTR8 : C_PTR16};
         op == OP_FL_TO_AH: r = '{DTX_FL_TO_AH, 1'b0, 1'b0, C_FL_AH}; // RULE12
         op == OP_AH_TO_FL: r = '{DTX_AH_TO_FL, 1'b0, 1'b0, C_AH_FL}; // RULE13
         op == OP_FL_SAVE: r.cls = DTX_FL_SAVE; // RULE15
         op == OP_FL_REST: r.cls = DTX_FL_REST; // RULE15
         // memory forms carry a mod/reg/rm byte that must not be decoded
         op == OP_SAVE_MEM: r = '{DTX_SAVE, 1'b0, 1'b1, C_DEFAULT}; // RULE15
         op == OP_REST_MEM: r = '{DTX_REST, 1'b0, 1'b1, C_DEFAULT}; // RULE15
         op == OP_SAVE_ALL ||
            (op & M_REG) == OP_SAVE_REG || (op & M_SEGR) == OP_SAVE_SEG ||
            (op & M_SIMM) == OP_SAVE_IMM:
            r.cls = DTX_SAVE; // RULE15
         op == OP_REST_ALL ||
            (op & M_REG) == OP_REST_REG || (op & M_SEGR) == OP_REST_SEG:
            r.cls = DTX_REST; // RULE15
         (op & M_W) == OP_R_TO_RM || (op & M_W) == OP_RM_TO_R ||
            (op & M_W) == OP_IMM_RM:
            r = '{DTX_XFER, 1'b0, 1'b1, C_DEFAULT}; // RULE14
         (op & M_IMM4) == OP_IMM_R || (op & M_W) == OP_MEM_ACC ||
            (op & M_W) == OP_ACC_MEM:
            r.cls = DTX_XFER; // RULE14
         (op & M_W) == OP_SWAP_RM: r = '{DTX_SWAP, 1'b0, 1'b1, C_DEFAULT}; // RULE14
         (op & M_REG) == OP_SWAP_ACC: r.cls = DTX_SWAP; // RULE14
         (op & M_W) == OP_IN_FIX || (op & M_W) == OP_OUT_FIX:
            r = '{DTX_PORT_FIX, 1'b0, 1'b1, C_DEFAULT}; // RULE16
         (op & M_W) == OP_IN_VAR || (op & M_W) == OP_OUT_VAR:
            r.cls = DTX_PORT_VAR; // RULE16
         default: r.cls = DTX_NONE;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // next-state: opcode, optional second byte, count down, bus slack
   always_comb
   begin
      st_nxt = st_r;
      opc_nxt = opc_r;
      cnt_nxt = cnt_r;
      hs_nxt = hs_r;
      dec_nxt = dec_r;
      ill_nxt = ill_r;
      done_nxt = 1'b0;
      o_q_pop = 1'b0;
      d = classify(i_q_byte);
      unique case (st_r)
         ST_OPC:
            if (i_q_valid)
            begin
               o_q_pop = 1'b1;
               opc_nxt = i_q_byte;
               dec_nxt = d;
               ill_nxt = 1'b0;
               st_nxt = d.needs_modrm ? ST_MODRM : ST_EXEC;
               cnt_nxt = d.clocks - OPC_SPENT; // RULE1
            end
         ST_MODRM:
            // second byte is a mod/reg/rm, or the fixed port byte
            if (i_q_valid)
            begin
               o_q_pop = 1'b1;
               st_nxt = ST_EXEC;
               if (dec_r.cls == DTX_SEG_LOAD && i_q_byte[7:6] != MOD_REG)
               begin
                  dec_nxt.mem = 1'b1; // RULE6
                  dec_nxt.clocks = NARROW_BUS ? C_SEGLD_M8 : C_SEGLD_M16;
               end
               if (dec_r.cls == DTX_SEG_STORE && i_q_byte[7:6] != MOD_REG)
               begin
                  dec_nxt.mem = 1'b1; // RULE7
                  dec_nxt.clocks = NARROW_BUS ? C_SEGST_M8 : C_SEGST_M16;
               end
               if ((dec_r.cls == DTX_PTR_DS || dec_r.cls == DTX_PTR_ES) &&
                   i_q_byte[7:6] == MOD_REG)
                  ill_nxt = 1'b1; // RULE10 RULE11
               // two-clock forms retire on the edge that takes the byte
               if (dec_nxt.clocks < PAIR_SPENT)
               begin
                  st_nxt = ST_OPC; // RULE1
                  done_nxt = 1'b1;
               end
               else
                  cnt_nxt = dec_nxt.clocks - PAIR_SPENT; // RULE1
            end
         ST_EXEC:
            if (cnt_r != 8'h00)
               cnt_nxt = cnt_r - 8'h01;
            else if (dec_r.mem && !ill_r && !i_mem_ack)
            begin
               // a prompt bus unit costs nothing; a late one at most two
               st_nxt = ST_WAIT; // RULE3
               hs_nxt = 2'h1;
            end
            else
            begin
               st_nxt = ST_OPC;
               done_nxt = 1'b1;
            end
         ST_WAIT:
            // wait on the bus unit, never beyond the allowed slack
            if (i_mem_ack || hs_r == HS_EXTRA_MAX)
            begin
               st_nxt = ST_OPC;
               done_nxt = 1'b1; // RULE3
            end
            else
               hs_nxt = hs_r + 2'h1;
      endcase
   end

   // register stage only
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         st_r <= ST_OPC;
         opc_r <= 8'h00;
         cnt_r <= 8'h00;
         hs_r <= 2'h0;
         dec_r <= '{DTX_NONE, 1'b0, 1'b0, 8'h00};
         ill_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         opc_r <= opc_nxt;
         cnt_r <= cnt_nxt;
         hs_r <= hs_nxt;
         dec_r <= dec_nxt;
         ill_r <= ill_nxt;
         done_r <= done_nxt;
      end
   end

   assign o_busy = (st_r != ST_OPC);
   assign o_done = done_r;
   assign o_class = dec_r.cls;
   assign o_clocks = dec_r.clocks;
   assign o_illegal = ill_r;
   assign o_q_depth = QDEPTH; // RULE4 RULE5

   ////////////////////////////////////////////////////////////////////
   // checks; RULE2 has no jump or call in this group
   sequence s_lea_start;
      st_r == ST_OPC && i_q_valid && i_q_byte == OP_EA_LOAD;
   endsequence

   AST_DEPTH: assert property (@(posedge i_ref_clk) // RULE4 RULE5
      o_q_depth == (NARROW_BUS ? 4'h4 : 4'h6))
      else $error("queue depth wrong for variant");
   AST_LEA_NOMEM: assert property (@(posedge i_ref_clk) // RULE9
      disable iff (!i_rstn) o_class == DTX_EA_LOAD |-> !dec_r.mem)
      else $error("effective address load marked as memory");
   AST_LEA_TIME: assert property (@(posedge i_ref_clk) // RULE9
      disable iff (!i_rstn) s_lea_start ##1 i_q_valid |=> ##4 o_done)
      else $error("effective address load not done in 6 clocks");
   AST_FL_AH: assert property (@(posedge i_ref_clk) // RULE12
      disable iff (!i_rstn)
      st_r == ST_OPC && i_q_valid && i_q_byte == OP_FL_TO_AH
      |=> ##1 o_done)
      else $error("flags to high byte not 2 clocks");
   AST_AH_FL: assert property (@(posedge i_ref_clk) // RULE13
      disable iff (!i_rstn)
      st_r == ST_OPC && i_q_valid && i_q_byte == OP_AH_TO_FL
      |=> !o_done ##1 !o_done ##1 o_done)
      else $error("high byte to flags not 3 clocks");
   AST_TBL_CLK: assert property (@(posedge i_ref_clk) // RULE8
      disable iff (!i_rstn) o_class == DTX_TABLE |->
      o_clocks == (NARROW_BUS ? 8'h0F : 8'h0B))
      else $error("table lookup count wrong");
   AST_PTR_CLK: assert property (@(posedge i_ref_clk) // RULE10 RULE11
      disable iff (!i_rstn)
      (o_class == DTX_PTR_DS || o_class == DTX_PTR_ES) |->
      o_clocks == (NARROW_BUS ? 8'h1A : 8'h12))
      else $error("pointer load count wrong");
   AST_SEGLD: assert property (@(posedge i_ref_clk) // RULE6
      disable iff (!i_rstn) o_class == DTX_SEG_LOAD && o_busy |->
      o_clocks == (dec_r.mem ? (NARROW_BUS ? 8'h0D : 8'h09) : 8'h02))
      else $error("segment load count wrong");
   AST_SEGST: assert property (@(posedge i_ref_clk) // RULE7
      disable iff (!i_rstn) o_class == DTX_SEG_STORE && o_busy |->
      o_clocks == (dec_r.mem ? (NARROW_BUS ? 8'h0F : 8'h0B) : 8'h02))
      else $error("segment store count wrong");
   AST_SLACK: assert property (@(posedge i_ref_clk) // RULE3
      disable iff (!i_rstn) st_r == ST_WAIT |-> ##[0:2] o_done)
      else $error("handshake slack exceeded");
   AST_DECODE: assert property (@(posedge i_ref_clk) // RULE16
      disable iff (!i_rstn) st_r == ST_OPC && i_q_valid &&
      (i_q_byte & M_W) == OP_IN_VAR |=> o_class == DTX_PORT_VAR)
      else $error("variable port form misdecoded");
   AST_SAVE: assert property (@(posedge i_ref_clk) // RULE15
      disable iff (!i_rstn) st_r == ST_OPC && i_q_valid &&
      i_q_byte == OP_FL_SAVE |=> o_class == DTX_FL_SAVE)
      else $error("flag save misdecoded");
endmodule

// ==== verif/dtx_queue_model.sv ====
// dtx_queue_model: prefetch queue and bus unit stand-in for one decoder.
// assumes: the bench loads bytes with put() while the decoder is idle.
`timescale 1ns/1ns
module dtx_queue_model (
   input wire logic i_ref_clk, // core clock
   input wire logic i_rstn, // sync reset, active low
   input wire logic i_pop, // decoder takes the head byte
   input wire logic i_busy, // decoder is executing
   input wire logic [1:0] i_ack_dly, // busy clocks before ack, 3: none
   output logic o_valid, // head byte present
   output logic [7:0] o_byte, // head byte
   output logic o_ack, // memory access finished
   output logic [4:0] o_taken // bytes taken since the last clear
);
   logic [7:0] mem_r [32];
   logic [4:0] wr_r;
   logic [1:0] cnt_r;
   logic [7:0] last_r;

   ////////////////////////////////////////////////////////////////////////
   // an empty queue shows the inverse of the last byte, so a stale value
   // never passes for a fresh opcode
   assign o_valid = o_taken < wr_r;
   assign o_byte = o_valid ? mem_r[o_taken] : ~last_r;
   // a delay of 3 stands for a bus unit that never answers in time
   assign o_ack = i_busy && i_ack_dly != 2'h3 && cnt_r >= i_ack_dly;

   // pop the head and count busy clocks toward the memory answer
   always @(posedge i_ref_clk)
   begin
      if (i_pop && o_valid)
      begin
         last_r <= mem_r[o_taken];
         o_taken <= o_taken + 5'h01;
      end
      if (!i_busy || !i_rstn)
         cnt_r <= 2'h0;
      else if (cnt_r != 2'h3)
         cnt_r <= cnt_r + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // operands are queued before they are needed
   task automatic clear();
      o_taken = 5'h00;
      wr_r = 5'h00;
   endtask

   task automatic put(input logic [7:0] b);
      mem_r[wr_r] = b;
      wr_r = wr_r + 5'h01;
   endtask

   initial
   begin
      last_r = 8'h00;
      cnt_r = 2'h0;
      clear();
   end
endmodule

// ==== verif/tb.sv ====
// tb: runs both bus variants of the decoder side by side on identical
// queue contents and checks class, clock count and timing.
// assumes: one dtx_queue_model per variant acts as the bus unit.
`timescale 1ns/1ns
module tb;
   import dtx_pkg::*;
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
   miscompares++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
   logic i_ref_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [1:0] ack_dly = 2'h0;
   int comparisons = 0;
   int miscompares = 0;
   int cyc = 0;
   int base [2];
   logic pop [2], busy [2], done [2], ill [2], valid [2], ack [2];
   logic [7:0] qb [2], clks [2];
   logic [3:0] depth [2];
   logic [4:0] taken [2];
   dtx_class_e cls [2];
   int n [2], gap [2], t0 [2], td [2], ndone [2];

   ////////////////////////////////////////////////////////////////////////
   // index 0 is the 16-bit-bus variant, index 1 the 8-bit-bus variant
   for (genvar v = 0; v < 2; v++)
   begin : g
      dtx_queue_model dtx_queue_model_inst (.i_ref_clk(i_ref_clk),
         .i_rstn(i_rstn), .i_pop(pop[v]), .i_busy(busy[v]),
         .i_ack_dly(ack_dly), .o_valid(valid[v]), .o_byte(qb[v]),
         .o_ack(ack[v]), .o_taken(taken[v]));
      dtx_decoder #(.NARROW_BUS(1'(v))) dtx_decoder_inst (
         .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_q_valid(valid[v]),
         .i_q_byte(qb[v]), .i_mem_ack(ack[v]), .o_q_pop(pop[v]),
         .o_busy(busy[v]), .o_done(done[v]), .o_class(cls[v]),
         .o_clocks(clks[v]), .o_illegal(ill[v]), .o_q_depth(depth[v]));
      // stamp each opcode take and each retirement
      always @(posedge i_ref_clk)
      begin
         if (pop[v] && !busy[v])
         begin
            t0[v] <= cyc;
            gap[v] <= done[v] ? 0 : cyc - td[v];
         end
         if (done[v])
         begin
            td[v] <= cyc;
            n[v] <= cyc - t0[v];
            ndone[v] <= ndone[v] + 1;
         end
      end
      initial ndone[v] = 0;
   end

   // clock and cycle count
   initial forever #4 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////
   // wait for quiet, empty both queues and note the retirement counts
   task automatic qstart();
      for (int k = 0; k < 40 && (busy[0] || busy[1]); k++)
         @(negedge i_ref_clk);
      `CHK("idle", 1'b0, busy[0] | busy[1])
      g[0].dtx_queue_model_inst.clear();
      g[1].dtx_queue_model_inst.clear();
      base = ndone;
   endtask

   task automatic qput(input logic [7:0] b);
      g[0].dtx_queue_model_inst.put(b);
      g[1].dtx_queue_model_inst.put(b);
   endtask

   task automatic qwait(input int k);
      bit ok;
      for (int j = 0; j < 90 && (ndone[0] < base[0] + k ||
           ndone[1] < base[1] + k); j++)
         @(negedge i_ref_clk);
      ok = ndone[0] >= base[0] + k && ndone[1] >= base[1] + k;
      `CHK("retired", 1'b1, ok)
   endtask

   // mode 0: exact count, 1: memory form, no answer costs the full
   // slack, 2: decode only
   task automatic exec(input logic [7:0] b0, b1, input bit two,
      input dtx_class_e ec, input logic [7:0] c16, c8, input int mode);
      logic [7:0] ce;
      qstart();
      qput(b0);
      if (two)
         qput(b1);
      qwait(1);
      for (int v = 0; v < 2; v++)
      begin
         ce = v ? c8 : c16;
         `CHK("class", ec, cls[v])
         if (mode != 2) `CHK("clocks", ce, clks[v])
         if (mode == 0) `CHK("cycles", int'(ce), n[v])
         if (mode == 1) `CHK("slack", int'(ce) + (ack_dly == 2'h3 ?
            int'(HS_EXTRA_MAX) : 0), n[v])
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int v = 0; v < 2; v++)
      begin
         `CHK("busy", 1'b0, busy[v])
         `CHK("done", 1'b0, done[v])
         `CHK("class", DTX_NONE, cls[v])
         `CHK("clocks", 8'h00, clks[v])
         `CHK("illegal", 1'b0, ill[v])
      end
      `CHK("depth16", 4'h6, depth[0])
      `CHK("depth8", 4'h4, depth[1])
   endtask

   // a slow bus unit must not stretch the register-only forms
   task automatic t_fixed();
      ack_dly = 2'h3;
      exec(8'h9F, 8'h00, 0, DTX_FL_TO_AH, 8'h02, 8'h02, 0);
      exec(8'h9E, 8'h00, 0, DTX_AH_TO_FL, 8'h03, 8'h03, 0);
      exec(8'h8D, 8'h06, 1, DTX_EA_LOAD, 8'h06, 8'h06, 0);
   endtask

   // memory forms, and the register forms of the segment moves, with a prompt and with a late bus unit
   task automatic t_mem();
      for (int d = 0; d < 4; d += 3)
      begin
         ack_dly = 2'(d);
         exec(8'h8E, 8'h06, 1, DTX_SEG_LOAD, 8'h09, 8'h0D, 1);
         exec(8'h8E, 8'hC0, 1, DTX_SEG_LOAD, 8'h02, 8'h02, 0);
         exec(8'h8C, 8'h06, 1, DTX_SEG_STORE, 8'h0B, 8'h0F, 1);
         exec(8'h8C, 8'hC3, 1, DTX_SEG_STORE, 8'h02, 8'h02, 0);
         exec(8'hD7, 8'h00, 0, DTX_TABLE, 8'h0B, 8'h0F, 1);
         exec(8'hC5, 8'h06, 1, DTX_PTR_DS, 8'h12, 8'h1A, 1);
         exec(8'hC4, 8'h06, 1, DTX_PTR_ES, 8'h12, 8'h1A, 1);
      end
   endtask

   task automatic t_illegal();
      exec(8'hC5, 8'hC0, 1, DTX_PTR_DS, 8'h12, 8'h1A, 2);
      `CHK("illegal", 1'b1, ill[0] & ill[1])
      exec(8'hC4, 8'hC7, 1, DTX_PTR_ES, 8'h12, 8'h1A, 2);
      `CHK("illegal", 1'b1, ill[0] & ill[1])
      exec(8'hC4, 8'h07, 1, DTX_PTR_ES, 8'h12, 8'h1A, 2);
      `CHK("illegal", 1'b0, ill[0] | ill[1])
   endtask

   // queued bytes wait while busy, then go back to back
   task automatic t_b2b();
      qstart();
      qput(8'h9F);
      qput(8'h9E);
      qput(8'h8D);
      qput(8'h06);
      qwait(3);
      for (int v = 0; v < 2; v++)
      begin
         `CHK("gap", 0, gap[v])
         `CHK("last", 6, n[v])
         `CHK("taken", 5'h04, taken[v])
      end
   endtask

   // pattern table: opcode and paired byte (00 when none), class
   task automatic t_table();
      logic [15:0] op [25] = '{16'h88C1, 16'h8BC1, 16'hC7C0, 16'hB300,
         16'hBB00, 16'hA000, 16'hA300, 16'h87C1, 16'h9300, 16'hFFF0,
         16'h8FC0, 16'h5200, 16'h5B00, 16'h0E00, 16'h1F00, 16'h6800,
         16'h6A00, 16'h6000, 16'h6100, 16'h9C00, 16'h9D00, 16'hE49F,
         16'hE79F, 16'hEC00, 16'hEF00};
      dtx_class_e ec [25] = '{DTX_XFER, DTX_XFER, DTX_XFER, DTX_XFER,
         DTX_XFER, DTX_XFER, DTX_XFER, DTX_SWAP, DTX_SWAP, DTX_SAVE,
         DTX_REST, DTX_SAVE, DTX_REST, DTX_SAVE, DTX_REST, DTX_SAVE,
         DTX_SAVE, DTX_SAVE, DTX_REST, DTX_FL_SAVE, DTX_FL_REST,
         DTX_PORT_FIX, DTX_PORT_FIX, DTX_PORT_VAR, DTX_PORT_VAR};
      for (int i = 0; i < 25; i++)
      begin
         exec(op[i][15:8], op[i][7:0], op[i][7:0] != 8'h00, ec[i],
            8'h00, 8'h00, 2);
         repeat (4) @(negedge i_ref_clk);
         `CHK("paired", ec[i], cls[0])
         `CHK("paired", ec[i], cls[1])
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // reset for eight clocks, then the scenarios in turn
   initial
   begin
      repeat (8) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      @(negedge i_ref_clk);
      t_reset();
      t_fixed();
      t_mem();
      t_illegal();
      t_b2b();
      t_table();
      stop_test();
   end

   // the scenarios need well under 5000 clocks
   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      miscompares++;
      stop_test();
   end
endmodule
